//--- pkg/host_port_cfg.svh
/*
  Offsets, field positions, reset values and timing counts for the host-port
  pointer and interrupt-shaping register bank.
  Assumes a 200 MHz system clock and a byte-addressed host register bus.
*/
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// ============================================================
// register offsets (byte addresses)
`define OFS_MEM_PTR        16'h033C
`define OFS_IRQ_SHAPE      16'h0340
`define OFS_DMA_PTR        16'h0344

// ============================================================
// field positions
`define MEM_BANK_HI        17
`define MEM_BANK_LO        16
`define START_HI           15
`define START_LO           0
`define GAP_HI             31
`define GAP_LO             24
`define PULSE_HI           15
`define PULSE_LO           0

// ============================================================
// reset values
`define PULSE_RST          16'h000F
`define GAP_RST            8'h00

// ============================================================
// timing
`define CLK_PERIOD_NS      5
`define UFRAME_US          125
`define UFRAME_CYCLES      ((`UFRAME_US * 1000) / `CLK_PERIOD_NS)

`endif

//--- pkg/host_port_pkg.sv
/*
  Types shared by the host-port register bank.
  Assumes the constants header is included by the files that need numbers.
*/
package host_port_pkg;

  typedef logic [1:0]  bank_t;
  typedef logic [15:0] addr16_t;

  typedef enum logic [1:0]
  {
    IRQ_IDLE  = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_GAP   = 2'b10
  } irq_state_e;

endpackage : host_port_pkg

//--- rtl/host_port_pointer_irq_regs.sv
/*
  Host-port support registers: banked PIO read pointers, edge interrupt
  shaping and the DMA start pointer.
  Assumes single-cycle register strobes from the host bus front end, a
  200 MHz clock, and that the memory array sits outside this block.
*/
`timescale 1ns/10ps
`include "host_port_cfg.svh"

module host_port_pointer_irq_regs
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // register bus
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // PIO memory access
  input  wire logic        pio_mem_rd,
  input  wire logic        pio_mem_wr,
  output logic      [1:0]  pio_bank,
  output logic      [15:0] pio_rd_addr,
  // DMA
  output logic      [15:0] dma_start_addr,
  // interrupt
  input  wire logic        irq_event,
  input  wire logic        irq_level_mode,
  output logic             irq_out
);

  logic [15:0]                  bank_ptr_r [4];
  host_port_pkg::bank_t         bank_sel_r;
  logic [7:0]                   gap_r;
  logic [15:0]                  pulse_len_r;
  host_port_pkg::irq_state_e    irq_state_r;
  logic [15:0]                  pulse_cnt_r;
  logic [7:0]                   uframe_cnt_r;
  logic [15:0]                  cyc_cnt_r;
  logic                         pend_r;

  logic wr_mem;
  logic wr_shape;
  logic wr_dma;
  logic rd_hit;
  logic rd_step;

  assign wr_mem   = reg_wr && (reg_addr == `OFS_MEM_PTR);
  assign wr_shape = reg_wr && (reg_addr == `OFS_IRQ_SHAPE);
  assign wr_dma   = reg_wr && (reg_addr == `OFS_DMA_PTR);
  assign rd_hit   = reg_rd;
  // a cycle that also strobes a write is not a read and must not use up an address
  assign rd_step  = pio_mem_rd && !pio_mem_wr;

  // ============================================================
  // banked PIO read pointers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_bank
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          bank_ptr_r[gi] <= 16'h0000;
        else if (wr_mem && reg_wdata[`MEM_BANK_HI:`MEM_BANK_LO] == 2'(gi))
          bank_ptr_r[gi] <= reg_wdata[`START_HI:`START_LO];
        else if (rd_step && bank_sel_r == 2'(gi))
          bank_ptr_r[gi] <= bank_ptr_r[gi] + 16'h0001;
      end
    end
  endgenerate

  // the bank choice also serves PIO writes; DMA never looks at it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bank_sel_r <= 2'h0;
    else if (wr_mem)
      bank_sel_r <= reg_wdata[`MEM_BANK_HI:`MEM_BANK_LO];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pio_bank <= 2'h0;
    else
      pio_bank <= wr_mem ? reg_wdata[`MEM_BANK_HI:`MEM_BANK_LO] : bank_sel_r;
  end

  // mirrors the selected bank's pointer as it stands after this edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pio_rd_addr <= 16'h0000;
    else if (wr_mem)
      pio_rd_addr <= reg_wdata[`START_HI:`START_LO];
    else if (rd_step)
      pio_rd_addr <= bank_ptr_r[bank_sel_r] + 16'h0001;
    else
      pio_rd_addr <= bank_ptr_r[bank_sel_r];
  end

  // ============================================================
  // DMA start pointer, write only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dma_start_addr <= 16'h0000;
    else if (wr_dma)
      dma_start_addr <= reg_wdata[`START_HI:`START_LO];
  end

  // ============================================================
  // edge interrupt shaping register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      gap_r <= `GAP_RST;
    else if (wr_shape)
      gap_r <= reg_wdata[`GAP_HI:`GAP_LO];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pulse_len_r <= `PULSE_RST;
    else if (wr_shape)
      pulse_len_r <= reg_wdata[`PULSE_HI:`PULSE_LO];
  end

  // ============================================================
  // register read-back; the DMA pointer is write only and reads zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (rd_hit)
    begin
      unique case (reg_addr)
        `OFS_MEM_PTR:   reg_rdata <= {14'h0000, bank_sel_r, bank_ptr_r[bank_sel_r]};
        `OFS_IRQ_SHAPE: reg_rdata <= {gap_r, 8'h00, pulse_len_r};
        default:        reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ============================================================
  // interrupt qualification
  // an edge starts only outside a pulse and once the gap has run out, even
  // if the gap was raised after the last pulse; a zero length drops the event
  logic fire;
  logic launch;
  logic gap_done;

  assign gap_done = (gap_r == 8'h00) || (uframe_cnt_r >= gap_r);
  assign fire     = (pend_r || irq_event) && !irq_level_mode
                    && (irq_state_r != host_port_pkg::IRQ_PULSE) && gap_done;
  assign launch   = fire && (pulse_len_r != 16'h0000);

  // ============================================================
  // pending event: one event is held while a pulse or gap runs; a new
  // event in the cycle that launches the held one wins over the clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pend_r <= 1'b0;
    else if (irq_level_mode)
      pend_r <= 1'b0;
    else if (irq_event && (pend_r || !fire))
      pend_r <= 1'b1;
    else if (fire)
      pend_r <= 1'b0;
  end

  // ============================================================
  // microframe timer, restarted at each pulse start; it resets to the
  // saturated count so the first edge after reset is never held back
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cyc_cnt_r    <= 16'h0000;
      uframe_cnt_r <= 8'hFF;
    end
    else if (launch)
    begin
      cyc_cnt_r    <= 16'h0000;
      uframe_cnt_r <= 8'h00;
    end
    else if (cyc_cnt_r == 16'(`UFRAME_CYCLES - 1))
    begin
      cyc_cnt_r <= 16'h0000;
      if (uframe_cnt_r != 8'hFF)
        uframe_cnt_r <= uframe_cnt_r + 8'h01;
    end
    else
      cyc_cnt_r <= cyc_cnt_r + 16'h0001;
  end

  // ============================================================
  // edge pulse sequencer; level mode parks it in idle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_state_r <= host_port_pkg::IRQ_IDLE;
      pulse_cnt_r <= 16'h0000;
    end
    else if (irq_level_mode)
    begin
      irq_state_r <= host_port_pkg::IRQ_IDLE;
      pulse_cnt_r <= 16'h0000;
    end
    else
    begin
      unique case (irq_state_r)
        host_port_pkg::IRQ_IDLE:
        begin
          if (launch)
          begin
            irq_state_r <= host_port_pkg::IRQ_PULSE;
            pulse_cnt_r <= pulse_len_r - 16'h0001;
          end
        end
        host_port_pkg::IRQ_PULSE:
        begin
          if (pulse_cnt_r == 16'h0000)
            irq_state_r <= host_port_pkg::IRQ_GAP;
          else
            pulse_cnt_r <= pulse_cnt_r - 16'h0001;
        end
        host_port_pkg::IRQ_GAP:
        begin
          // with a zero gap the next edge may follow after one low cycle
          if (launch)
          begin
            irq_state_r <= host_port_pkg::IRQ_PULSE;
            pulse_cnt_r <= pulse_len_r - 16'h0001;
          end
          else if (gap_done)
            irq_state_r <= host_port_pkg::IRQ_IDLE;
        end
        default:
          irq_state_r <= host_port_pkg::IRQ_IDLE;
      endcase
    end
  end

  // ============================================================
  // interrupt line: the event itself in level mode, else high from a
  // launch until the pulse count runs out
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_out <= 1'b0;
    else if (irq_level_mode)
      irq_out <= irq_event;
    else if (launch)
      irq_out <= 1'b1;
    else if (irq_state_r != host_port_pkg::IRQ_PULSE || pulse_cnt_r == 16'h0000)
      irq_out <= 1'b0;
  end

endmodule : host_port_pointer_irq_regs

//--- testbench/host_cpu_model.sv
/*
  Host processor model driving single-cycle register strobes.
  Assumes the bench calls acc; signals change at falling edges only.
*/
`timescale 1ns/10ps
module host_cpu_model
(
  // register bus
  input  wire logic        clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_addr,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata
);
  // ============================================================
  // one access; idle address and data inverted so stale values never match
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 32'h0;
  end
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(negedge clk);
    q         = reg_rdata;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : acc
endmodule : host_cpu_model

//--- testbench/host_port_pointer_irq_regs_sva.sv
/*
  Assertions on the host-port register bank ports.
  Assumes a 200 MHz clk, nrst active low, shaping fields stable during a pulse.
*/
`timescale 1ns/10ps
module host_port_regs_chk
(
  // clock, reset and register bus
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // pio, dma and interrupt
  input wire logic        pio_mem_rd,
  input wire logic        pio_mem_wr,
  input wire logic [1:0]  pio_bank,
  input wire logic [15:0] pio_rd_addr,
  input wire logic [15:0] dma_start_addr,
  input wire logic        irq_event,
  input wire logic        irq_level_mode,
  input wire logic        irq_out
);
  // ============================================================
  // shadow fields and counters
  // microframe in clocks, fixed because the clock is fixed at 200 MHz
  localparam logic [31:0] UF_CYC = 32'h0000_61A8;
  logic [15:0] len_r;
  logic [7:0]  gap_r;
  logic [31:0] run_r;
  logic [31:0] since_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      len_r <= 16'h000F;
      gap_r <= 8'h00;
    end
    else if (reg_wr && reg_addr == 16'h0340)
    begin
      len_r <= reg_wdata[15:0];
      gap_r <= reg_wdata[31:24];
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      run_r <= 32'h0;
    else
      run_r <= irq_out ? run_r + 32'h1 : 32'h0;
  end
  // starts large so the first pulse after reset is never too early
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      since_r <= 32'hFFFF_0000;
    else
      since_r <= (irq_out && run_r == 32'h0) ? 32'h1 : since_r + 32'h1;
  end
  // ============================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_bank;
    reg_wr && reg_addr == 16'h033C |=> pio_bank == $past(reg_wdata[17:16]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank not taken");
  property p_start;
    reg_wr && reg_addr == 16'h033C |=> pio_rd_addr == $past(reg_wdata[15:0]);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_inc;
    pio_mem_rd && !pio_mem_wr && !reg_wr |=> pio_rd_addr == $past(pio_rd_addr) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer not advanced");
  property p_wrhold;
    pio_mem_wr && !reg_wr |=> pio_rd_addr == $past(pio_rd_addr);
  endproperty
  a_wrhold: assert property (p_wrhold) else $error("pointer moved on write");
  property p_dma;
    reg_wr && reg_addr == 16'h0344 |=> dma_start_addr == $past(reg_wdata[15:0]);
  endproperty
  a_dma: assert property (p_dma) else $error("dma start not taken");
  property p_dmard;
    reg_rd && reg_addr == 16'h0344 |=> reg_rdata == 32'h0;
  endproperty
  a_dmard: assert property (p_dmard) else $error("dma pointer readable");
  property p_level;
    irq_level_mode && $past(irq_level_mode) |-> irq_out == $past(irq_event);
  endproperty
  a_level: assert property (p_level) else $error("level irq wrong");
  property p_pulse;
    $fell(irq_out) && !irq_level_mode |-> run_r == {16'h0, len_r};
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length wrong");
  property p_gap;
    $rose(irq_out) && !irq_level_mode |-> since_r >= {24'h0, gap_r} * UF_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("edges too close");
endmodule : host_port_regs_chk

bind host_port_pointer_irq_regs host_port_regs_chk u_chk
(
  .clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pio_mem_rd,
  .pio_mem_wr, .pio_bank, .pio_rd_addr, .dma_start_addr, .irq_event,
  .irq_level_mode, .irq_out
);

//--- testbench/host_port_pointer_irq_regs_tb_top.sv
/*
  Self-checking bench for the host-port register bank.
  Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/10ps
module host_port_pointer_irq_regs_tb_top;
  // ============================================================
  // signals and model state
  logic        clk, nrst, pio_mem_rd, pio_mem_wr, irq_event, irq_level_mode, lv;
  logic        reg_wr, reg_rd, irq_out;
  logic [15:0] reg_addr, pio_rd_addr, dma_start_addr;
  logic [31:0] reg_wdata, reg_rdata, s, q, e;
  logic [1:0]  pio_bank;
  int          failures, n_tests, k, j, w, h;
  int          ptr [4];
  always #2.5 clk = ~clk;
  host_cpu_model u_host_cpu_model (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
                                   .reg_rdata);
  host_port_pointer_irq_regs u_host_port_pointer_irq_regs (.clk, .nrst, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pio_mem_rd, .pio_mem_wr, .pio_bank,
    .pio_rd_addr, .dma_start_addr, .irq_event, .irq_level_mode, .irq_out);
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic print_verdict();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // bounded wait for a rising irq, then length of its high time
  task automatic meas(input int lim);
    w = 0;
    h = 0;
    while (irq_out !== 1'b1 && w < lim)
    begin
      @(negedge clk);
      w++;
    end
    while (irq_out === 1'b1 && h < 70000)
    begin
      @(negedge clk);
      h++;
    end
    if (w >= lim)
    begin
      failures++;
      print_verdict();
    end
  endtask : meas
  task automatic ev();
    irq_event = 1'b1;
    @(negedge clk);
    irq_event = 1'b0;
  endtask : ev
  initial
  begin
    repeat (100000) @(negedge clk);
    failures++;
    print_verdict();
  end
  // ============================================================
  // main sequence
  initial
  begin
    {clk, nrst, pio_mem_rd, pio_mem_wr, irq_event, irq_level_mode} = 6'h00;
    {failures, n_tests} = 0;
    s = 32'h0001_533D;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    u_host_cpu_model.acc(1'b0, 16'h0340, 32'h0, q);
    chk(q, 32'h0000_000F);
    for (k = 0; k < 4; k++)
    begin
      e = rnd();
      ptr[k] = {16'h0, e[15:0]};
      u_host_cpu_model.acc(1'b1, 16'h033C, {14'h0, k[1:0], e[15:0]}, q);
      for (j = 0; j < 8; j++)
      begin
        e = rnd();
        {pio_mem_wr, pio_mem_rd} = e[1:0];
        ptr[k] += {31'h0, e[0] & ~e[1]};
        @(negedge clk);
      end
      {pio_mem_wr, pio_mem_rd} = 2'h0;
      chk({16'h0, pio_rd_addr}, {16'h0, ptr[k][15:0]});
      u_host_cpu_model.acc(1'b0, 16'h033C, 32'h0, q);
      chk(q, {14'h0, k[1:0], ptr[k][15:0]});
    end
    e = rnd();
    u_host_cpu_model.acc(1'b1, 16'h0344, {16'h0, e[15:0]}, q);
    chk({16'h0, dma_start_addr}, {16'h0, e[15:0]});
    chk({30'h0, pio_bank}, 32'h0000_0003);
    u_host_cpu_model.acc(1'b0, 16'h0344, 32'h0, q);
    chk(q, 32'h0);
    u_host_cpu_model.acc(1'b0, 16'h0350, 32'h0, q);
    chk(q, 32'h0);
    u_host_cpu_model.acc(1'b1, 16'h0340, 32'h0000_0003, q);
    for (k = 0; k < 2; k++)
    begin
      ev();
      meas(10);
      chk(w, 0);
      chk(h, 3);
    end
    u_host_cpu_model.acc(1'b1, 16'h0340, 32'h0100_0003, q);
    ev();
    meas(30000);
    chk({31'h0, w + 6 >= 25000 && w + 6 < 25010}, 32'h1);
    chk(h, 3);
    ev();
    meas(30000);
    chk({31'h0, w + 4 >= 25000 && w + 4 < 25010}, 32'h1);
    chk(h, 3);
    irq_level_mode = 1'b1;
    lv = 1'b0;
    for (k = 0; k < 24; k++)
    begin
      @(negedge clk);
      chk({31'h0, irq_out}, {31'h0, lv});
      e = rnd();
      irq_event = e[3];
      lv = e[3];
    end
    irq_event = 1'b0;
    print_verdict();
  end
endmodule : host_port_pointer_irq_regs_tb_top
